// [logic/safety_relay_output_mapper.sv]
// Top of the four-relay safety output mapper: command map, fallback, errors.
// Assumes synchronous inputs; relay fault and readback come from the drivers.
`timescale 1ns/100ps
module safety_relay_output_mapper #(
  parameter int CYCLES_PER_MS = relay_map_pkg::CYCLES_PER_MS,
  parameter int MINUTE_MS = relay_map_pkg::MS_PER_MINUTE
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [3:0] i_selection,
  input wire logic [relay_map_pkg::RELAYS-1:0] i_cmd,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_fallback_timeout_ms,
  input wire logic [relay_map_pkg::RELAYS-1:0] i_channel_fallback_choice,
  input wire logic [relay_map_pkg::RELAYS-1:0] i_channel_fallback_value,
  input wire logic [10:0] i_test_period_min,
  input wire logic [relay_map_pkg::RELAYS-1:0] i_relay_readback,
  input wire logic [relay_map_pkg::RELAYS-1:0] i_relay_fault,
  input wire logic i_error_clear,
  output logic [relay_map_pkg::RELAYS-1:0] o_relay,
  output logic o_selection_valid,
  output logic [2:0] o_output_count,
  output logic o_auto_test,
  output logic o_fallback,
  output logic o_test_busy,
  output logic [relay_map_pkg::RELAYS-1:0] o_relay_error
);
  import relay_map_pkg::*;

  typedef struct packed {
    logic [15:0] div;
    logic tick;
    logic [15:0] since;
    logic seen;
    logic fb;
    logic [3:0] last;
    logic [3:0] err;
    logic [3:0] relay;
    logic valid;
    logic [2:0] count;
    logic auto;
  } map_s;

  map_s s_q;
  map_s s_d;
  sel_cfg_s cfg;
  logic [3:0] eff;
  logic [3:0] base;
  logic [3:0] errs;
  logic [3:0] kill;
  logic [3:0] base_k;
  logic [3:0] pulse_eff;

  relay_test_if itf();

  // Decode of the configured wiring selection
  always_comb begin
    cfg = decode_sel(i_selection);
  end

  // Effective logical command: nothing before first frame, fallback after silence
  always_comb begin
    eff = s_q.last;
    if (s_q.fb) begin
      eff = (i_channel_fallback_choice & i_channel_fallback_value) |
            (~i_channel_fallback_choice & s_q.last);
    end
    if (!s_q.seen) eff = RELAYS_OFF;
  end

  // Logical outputs onto relays; both relays of a pair follow one logical bit
  always_comb begin
    case (cfg.relays_per)
      RPO_ONE: base = eff;
      RPO_TWO: base = {{2{eff[1]}}, {2{eff[0]}}};
      RPO_FOUR: base = {4{eff[0]}};
      default: base = RELAYS_OFF;
    endcase
  end

  // Fault on any relay of an output drops the whole output
  always_comb begin
    errs = s_q.err | i_relay_fault;
    case (cfg.relays_per)
      RPO_ONE: kill = errs;
      RPO_TWO: kill = {{2{|errs[3:2]}}, {2{|errs[1:0]}}};
      RPO_FOUR: kill = {4{|errs}};
      default: kill = RELAYS_ALL;
    endcase
    base_k = base & ~kill;
  end

  // Test pulse only moves a relay out of its idle level, so the load holds
  always_comb begin
    pulse_eff = itf.pulse & (cfg.normal_on ? base_k : ~base_k) & ~kill;
    if (!cfg.auto_test) pulse_eff = RELAYS_OFF;
  end

  // Tester hookup; no test before the first frame, where a pulse could
  // energize a relay that must still be off
  assign itf.tick_ms = s_q.tick;
  assign itf.enable = cfg.valid && cfg.auto_test && s_q.seen;
  assign itf.normal_on = cfg.normal_on;
  assign itf.period_min = i_test_period_min;
  assign itf.base = base_k;
  assign itf.readback = i_relay_readback;

  relay_pulse_tester #(
    .MINUTE_MS(MINUTE_MS)
  ) u_tester (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .t(itf)
  );

  // Next state of the mapper
  always_comb begin
    s_d = s_q;
    // Millisecond tick drives both the silence timer and the tester
    s_d.tick = (s_q.div == 16'(CYCLES_PER_MS - 1));
    s_d.div = s_d.tick ? 16'h0 : s_q.div + 16'h1;
    if (s_q.tick && s_q.since != 16'hffff) begin
      s_d.since = s_q.since + 16'h1; // Saturates, never wraps back
    end
    s_d.fb = s_q.seen && (s_q.since > i_fallback_timeout_ms);
    if (i_cmd_valid) begin
      s_d.since = 16'h0;
      s_d.fb = 1'b0;
      s_d.seen = 1'b1;
      s_d.last = i_cmd;
    end
    // Sticky errors; a new fault beats a clear in the same cycle
    s_d.err = (s_q.err & ~{4{i_error_clear}}) | i_relay_fault | itf.mismatch;
    if (cfg.valid) s_d.relay = base_k ^ pulse_eff;
    else s_d.relay = RELAYS_OFF;
    s_d.valid = cfg.valid;
    s_d.count = cfg.outputs;
    s_d.auto = cfg.auto_test;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) s_q <= '0;
    else s_q <= s_d;
  end

  // All outputs straight from flops except the tester busy level
  assign o_relay = s_q.relay;
  assign o_selection_valid = s_q.valid;
  assign o_output_count = s_q.count;
  assign o_auto_test = s_q.auto;
  assign o_fallback = s_q.fb;
  assign o_test_busy = itf.busy;
  assign o_relay_error = s_q.err;

  // Checks next to the logic they guard
  a_unseen_all_off: assert property (@(posedge i_clock) disable iff (i_srst)
    !s_q.seen |-> o_relay == 4'h0) else $error("relay on before first command");

  a_invalid_sel_off: assert property (@(posedge i_clock) disable iff (i_srst)
    !cfg.valid |=> o_relay == 4'h0) else $error("relay on with bad selection");

  a_single_relay_map: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_cmd_valid && i_selection == 4'h1 && s_q.err == 4'h0 && i_relay_fault == 4'h0)
    ##1 (i_selection == 4'h1 && i_relay_fault == 4'h0 && s_q.err == 4'h0)
    |=> o_relay == $past(i_cmd, 2)) else $error("selection 1 map wrong");

  a_pair_relay_map: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_cmd_valid && i_selection == 4'h5 && s_q.err == 4'h0 && i_relay_fault == 4'h0)
    ##1 (i_selection == 4'h5 && i_relay_fault == 4'h0 && s_q.err == 4'h0)
    |=> o_relay == {{2{$past(i_cmd[1], 2)}}, {2{$past(i_cmd[0], 2)}}})
    else $error("selection 5 map wrong");

  a_quad_moves_together: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_selection == 4'h6 && itf.pulse == 4'h0) |=> (o_relay == 4'h0 || o_relay == 4'hf))
    else $error("selection 6 relays split");

  a_group_kill_pair: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_selection == 4'h2 && |s_q.err[1:0]) |=> o_relay[1:0] == 2'h0)
    else $error("faulted pair still driven");

  a_test_invisible: assert property (@(posedge i_clock) disable iff (i_srst)
    (itf.enable && itf.normal_on) |=> (o_relay & ~$past(itf.base)) == 4'h0)
    else $error("test pulse energized an idle relay");

  a_manual_no_pulse: assert property (@(posedge i_clock) disable iff (i_srst)
    (!cfg.auto_test && !$past(cfg.auto_test)) |-> itf.pulse == 4'h0)
    else $error("pulse in manual-test selection");

  a_fallback_entry: assert property (@(posedge i_clock) disable iff (i_srst)
    $rose(s_q.fb) |-> $past(s_q.since) > $past(i_fallback_timeout_ms))
    else $error("fallback entered before timeout");

  a_fallback_user_value: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_selection == 4'h1 && s_q.fb && i_channel_fallback_choice == 4'hf &&
     s_q.err == 4'h0 && i_relay_fault == 4'h0)
    |=> o_relay == $past(i_channel_fallback_value)) else $error("fallback value wrong");

  a_count_quad: assert property (@(posedge i_clock) disable iff (i_srst)
    i_selection == 4'h6 |=> o_output_count == 3'h1) else $error("output count wrong");

  // Table, fault latch and fallback checks
  a_count_single: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_selection == 4'h1 || i_selection == 4'h3) |=> o_output_count == 3'h4)
    else $error("single-relay output count wrong");

  a_auto_flag_table: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_selection == 4'h2 || i_selection == 4'h4 || i_selection == 4'h6 ||
     i_selection == 4'h8) |=> o_auto_test) else $error("auto test flag missing");

  a_invalid_count_zero: assert property (@(posedge i_clock) disable iff (i_srst)
    !cfg.valid |=> (o_output_count == 3'h0 && !o_auto_test && !o_selection_valid))
    else $error("invalid selection reported as usable");

  a_quad_group_kill: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_selection == 4'h6 && |s_q.err) |=> o_relay == 4'h0)
    else $error("faulted quad output still driven");

  a_fault_sets_error: assert property (@(posedge i_clock) disable iff (i_srst)
    (|i_relay_fault) |=> (o_relay_error & $past(i_relay_fault)) == $past(i_relay_fault))
    else $error("relay fault not latched");

  a_error_sticky: assert property (@(posedge i_clock) disable iff (i_srst)
    (|s_q.err && !i_error_clear) |=> (o_relay_error & $past(s_q.err)) == $past(s_q.err))
    else $error("relay error lost without clear");

  a_fallback_exit: assert property (@(posedge i_clock) disable iff (i_srst)
    i_cmd_valid |=> !o_fallback)
    else $error("fallback kept after new command");

  a_no_fallback_unseen: assert property (@(posedge i_clock) disable iff (i_srst)
    !s_q.seen |-> !o_fallback)
    else $error("fallback before first command");

endmodule

// [logic/relay_map_pkg.sv]
// Constants, selection table and types for the four-relay safety output mapper.
// Assumes one 40 MHz clock and synchronous inputs from the backplane side.
//
// Functional notes
// - Four relays, up to four logical outputs
// - Exactly eight selections, each fully fixed
// - Selections 1-4: lower-integrity wiring table
// - Selections 5-8: higher-integrity wiring table
// - Automatic test never changes actuator state
// - Relay self-test only in auto-test selections
// - Fallback after communication silence beyond timeout
// - Sequential relay pulses under 50 ms, periodic
// - Fault on one relay kills its group
// - Per channel: hold last or user value
package relay_map_pkg;

  localparam int CLOCK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
  localparam int MS_PER_MINUTE = 60000;
  localparam int PULSE_MS = 10;
  localparam int MAX_PULSE_MS = 50;
  localparam int RELAYS = 4;
  localparam int SELECTIONS = 8;

  localparam logic [10:0] PERIOD_MIN_LO = 11'h001;
  localparam logic [10:0] PERIOD_MIN_HI = 11'h5a0;
  localparam logic [3:0] RELAYS_OFF = 4'h0;
  localparam logic [3:0] RELAYS_ALL = 4'hf;

  localparam logic [2:0] RPO_ONE = 3'h1;
  localparam logic [2:0] RPO_TWO = 3'h2;
  localparam logic [2:0] RPO_FOUR = 3'h4;

  typedef struct packed {
    logic valid;
    logic energized;
    logic [2:0] relays_per;
    logic [2:0] outputs;
    logic auto_test;
    logic normal_on;
  } sel_cfg_s;

  // Wiring table; normal_on is the idle relay level that a test pulse leaves
  function automatic sel_cfg_s decode_sel(input logic [3:0] sel);
    sel_cfg_s c;
    c = '0;
    case (sel)
      4'h1: c = '{1'b1, 1'b0, RPO_ONE, 3'h4, 1'b0, 1'b0};
      4'h2: c = '{1'b1, 1'b0, RPO_TWO, 3'h2, 1'b1, 1'b1};
      4'h3: c = '{1'b1, 1'b1, RPO_ONE, 3'h4, 1'b0, 1'b0};
      4'h4: c = '{1'b1, 1'b1, RPO_TWO, 3'h2, 1'b1, 1'b1};
      4'h5: c = '{1'b1, 1'b0, RPO_TWO, 3'h2, 1'b0, 1'b0};
      4'h6: c = '{1'b1, 1'b0, RPO_FOUR, 3'h1, 1'b1, 1'b1};
      4'h7: c = '{1'b1, 1'b1, RPO_TWO, 3'h2, 1'b0, 1'b0};
      4'h8: c = '{1'b1, 1'b1, RPO_TWO, 3'h2, 1'b1, 1'b0};
      default: c = '0;
    endcase
    return c;
  endfunction

endpackage

// [logic/relay_test_if.sv]
// Carrier between the output mapper and its relay pulse tester.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface relay_test_if;
  logic tick_ms;
  logic enable;
  logic normal_on;
  logic [10:0] period_min;
  logic [3:0] base;
  logic [3:0] readback;
  logic [3:0] pulse;
  logic [3:0] mismatch;
  logic busy;

  modport mapper(
    output tick_ms, enable, normal_on, period_min, base, readback,
    input pulse, mismatch, busy
  );
  modport tester(
    input tick_ms, enable, normal_on, period_min, base, readback,
    output pulse, mismatch, busy
  );
endinterface

// [logic/relay_pulse_tester.sv]
// Periodic sequential relay pulse test with readback check.
// Assumes a one-cycle millisecond tick and an already masked relay base.
`timescale 1ns/100ps
module relay_pulse_tester #(
  parameter int MINUTE_MS = relay_map_pkg::MS_PER_MINUTE
) (
  input wire logic i_clock,
  input wire logic i_srst,
  relay_test_if.tester t
);
  import relay_map_pkg::*;

  typedef enum logic {T_IDLE, T_PULSE} tst_e;

  typedef struct packed {
    tst_e st;
    logic [15:0] ms;
    logic [10:0] mins;
    logic [1:0] idx;
    logic [7:0] pms;
    logic [3:0] pulse;
    logic [3:0] mism;
    logic [7:0] hold;
  } tst_s;

  tst_s q;
  tst_s d;
  logic [10:0] period;

  // Next state; period clamped into the legal minute range
  always_comb begin
    period = t.period_min;
    if (period < PERIOD_MIN_LO) period = PERIOD_MIN_LO;
    if (period > PERIOD_MIN_HI) period = PERIOD_MIN_HI;
    d = q;
    d.mism = 4'h0;
    case (q.st)
      T_IDLE: begin
        d.pulse = 4'h0;
        if (t.tick_ms) begin
          if (q.ms == 16'(MINUTE_MS - 1)) begin
            d.ms = 16'h0;
            if ((q.mins + 11'h1) >= period) begin
              d.mins = 11'h0;
              d.st = T_PULSE;
              d.idx = 2'h0;
              d.pms = 8'h0;
              d.pulse = (t.base[0] == t.normal_on) ? 4'h1 : 4'h0;
            end else begin
              d.mins = q.mins + 11'h1;
            end
          end else begin
            d.ms = q.ms + 16'h1;
          end
        end
      end
      T_PULSE: begin
        // Drop a pulse at once if the command left the idle level
        d.pulse = q.pulse & (t.normal_on ? t.base : ~t.base);
        if (t.tick_ms) begin
          if (q.pms == 8'(PULSE_MS - 1)) begin
            d.mism[q.idx] = q.pulse[q.idx] && (t.readback[q.idx] == t.normal_on);
            d.pms = 8'h0;
            d.idx = q.idx + 2'h1;
            d.pulse = (t.base[d.idx] == t.normal_on) ? (4'h1 << d.idx) : 4'h0;
            if (q.idx == 2'h3) begin
              d.st = T_IDLE;
              d.pulse = 4'h0;
            end
          end else begin
            d.pms = q.pms + 8'h1;
          end
        end
      end
      default: d = '0;
    endcase
    // Manual-test selections never pulse
    if (!t.enable) begin
      d.st = T_IDLE;
      d.pulse = 4'h0;
    end
    // Pulse age in ticks; restarts on each relay so the bound is per pulse
    if (d.pulse == 4'h0 || d.pulse != q.pulse) d.hold = 8'h0;
    else if (t.tick_ms) d.hold = q.hold + 8'h1;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) q <= '0;
    else q <= d;
  end

  assign t.pulse = q.pulse;
  assign t.mismatch = q.mism;
  assign t.busy = (q.st == T_PULSE);

  a_pulse_single_relay: assert property (@(posedge i_clock) disable iff (i_srst)
    $onehot0(q.pulse)) else $error("more than one relay pulsed");
  a_pulse_short_hold: assert property (@(posedge i_clock) disable iff (i_srst)
    q.hold <= 8'(PULSE_MS)) else $error("test pulse held too long");
  a_pulse_off_disabled: assert property (@(posedge i_clock) disable iff (i_srst)
    !t.enable |=> t.pulse == 4'h0) else $error("pulse while test disabled");
endmodule

// [tb/relay_bank_model.sv]
// Relay bank behind the mapper: contacts follow the coil drivers.
// Assumes the bench sets the stuck mask to imitate a welded contact.
`timescale 1ns/100ps
module relay_bank_model (
  input wire logic i_clock,
  input wire logic [3:0] i_drive,
  input wire logic [3:0] i_stuck_mask,
  input wire logic [3:0] i_stuck_value,
  output logic [3:0] o_readback
);
  // One cycle of contact travel; a stuck contact ignores its coil
  always_ff @(posedge i_clock) begin
    o_readback <= (i_drive & ~i_stuck_mask) | (i_stuck_value & i_stuck_mask);
  end
endmodule

// [tb/safety_relay_output_mapper_bench.sv]
// Bench for the relay output mapper: wiring table, fallback, faults, pulse test.
// Assumes the relay bank model closes the readback loop.
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module safety_relay_output_mapper_bench;
  import relay_map_pkg::*;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [3:0] sel = 4'h0;
  logic [3:0] cmd = 4'h0;
  logic cmd_valid = 1'b0;
  logic [15:0] timeout_ms = 16'hffff;
  logic [3:0] fb_choice = 4'h0;
  logic [3:0] fb_value = 4'h0;
  logic [10:0] period = 11'h5a0;
  logic [3:0] fault = 4'h0;
  logic err_clear = 1'b0;
  logic [3:0] stuck_mask = 4'h0;
  logic [3:0] stuck_value = 4'h0;
  logic [3:0] readback, relay, relay_error;
  logic sel_valid, auto_test, fallback, busy;
  logic [2:0] count;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  int pulses;

  // 40 MHz
  always #12.5 i_clock = ~i_clock;

  // Short millisecond and minute so a pulse test fits in a few hundred cycles
  safety_relay_output_mapper #(.CYCLES_PER_MS(4), .MINUTE_MS(50)) u_dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_selection(sel), .i_cmd(cmd),
    .i_cmd_valid(cmd_valid), .i_fallback_timeout_ms(timeout_ms),
    .i_channel_fallback_choice(fb_choice), .i_channel_fallback_value(fb_value),
    .i_test_period_min(period), .i_relay_readback(readback),
    .i_relay_fault(fault), .i_error_clear(err_clear), .o_relay(relay),
    .o_selection_valid(sel_valid), .o_output_count(count), .o_auto_test(auto_test),
    .o_fallback(fallback), .o_test_busy(busy), .o_relay_error(relay_error)
  );

  relay_bank_model u_bank (
    .i_clock(i_clock), .i_drive(relay), .i_stuck_mask(stuck_mask),
    .i_stuck_value(stuck_value), .o_readback(readback)
  );

  // Expected relay pattern per selection
  function automatic logic [3:0] map_exp(input int s, input logic [3:0] c);
    case (s)
      1, 3: return c;
      2, 4, 5, 7, 8: return {{2{c[1]}}, {2{c[0]}}};
      6: return {4{c[0]}};
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [2:0] count_exp(input int s);
    if (s == 1 || s == 3) return 3'h4;
    if (s == 6) return 3'h1;
    if (s >= 2 && s <= 8) return 3'h2;
    return 3'h0;
  endfunction

  // Settle just past an edge so registered outputs are stable
  task automatic step(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask

  // One command frame, returns when its relays are driven
  task automatic send(input logic [3:0] v);
    @(posedge i_clock);
    cmd <= v;
    cmd_valid <= 1'b1;
    @(posedge i_clock);
    cmd_valid <= 1'b0;
    step(2);
  endtask

  // Bounded wait on busy or fallback; a hang ends the run
  task automatic wait_for(input bit on_busy, input int limit);
    n = 0;
    while ((on_busy ? busy : fallback) !== 1'b1) begin
      if (n++ == limit) begin
        miscompares++;
        summarize();
      end
      step(1);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    #1;
    `CHK(relay, 4'h0)
    `CHK(count, 3'h0)
    // Selection numbers 0 to 9, valid and not, with two command patterns
    for (int s = 0; s < 10; s++) begin
      @(posedge i_clock);
      sel <= 4'(s);
      step(3);
      `CHK(sel_valid, logic'(s >= 1 && s <= 8))
      `CHK(count, count_exp(s))
      `CHK(auto_test, logic'(s inside {2, 4, 6, 8}))
      `CHK(relay, map_exp(s, 4'ha))
      for (int k = 0; k < 2; k++) begin
        send(k ? 4'ha : 4'h5);
        `CHK(relay, map_exp(s, k ? 4'ha : 4'h5))
      end
    end
    // Silence beyond timeout: bits 0,1 user value and 2,3 held, then all user value
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      sel <= 4'h1;
      timeout_ms <= 16'h0003;
      fb_choice <= k ? 4'hf : 4'h3;
      fb_value <= 4'h1;
      send(4'he);
      wait_for(1'b0, 100);
      step(2);
      `CHK(relay, k ? 4'h1 : 4'hd)
      send(4'h2);
      `CHK(fallback, 1'b0)
      `CHK(relay, 4'h2)
    end
    // Fault on one relay of a pair, then on the four-relay output
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      sel <= k ? 4'h6 : 4'h2;
      timeout_ms <= 16'hffff;
      send(k ? 4'h1 : 4'h3);
      `CHK(relay, 4'hf)
      @(posedge i_clock);
      fault <= k ? 4'h2 : 4'h4;
      step(3);
      `CHK(relay, k ? 4'h0 : 4'h3)
      `CHK(relay_error & fault, fault)
      @(posedge i_clock);
      fault <= 4'h0;
      err_clear <= 1'b1;
      @(posedge i_clock);
      err_clear <= 1'b0;
      step(2);
      `CHK(relay_error, 4'h0)
    end
    // Manual-test selection never starts a pulse test
    @(posedge i_clock);
    sel <= 4'h1;
    period <= 11'h001;
    repeat (300) begin
      step(1);
      `CHK(busy, 1'b0)
    end
    // Pulse test on paired relays: actuator stays energized
    @(posedge i_clock);
    sel <= 4'h2;
    send(4'h3);
    wait_for(1'b1, 400);
    n = 0;
    pulses = 0;
    while (busy === 1'b1 && n < 400) begin
      `CHK((relay[0] | relay[1]) & (relay[2] | relay[3]), 1'b1)
      `CHK($countones(~relay) <= 1, 1'b1)
      if (relay !== 4'hf) pulses++;
      n++;
      step(1);
    end
    `CHK(busy, 1'b0)
    `CHK(n < 4 * MAX_PULSE_MS, 1'b1)
    `CHK(pulses > 0, 1'b1)
    `CHK(relay_error, 4'h0)
    // Welded contact on relay 1 fails the next test, its pair drops
    @(posedge i_clock);
    stuck_mask <= 4'h2;
    stuck_value <= 4'h2;
    wait_for(1'b1, 400);
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      n++;
      step(1);
    end
    `CHK(busy, 1'b0)
    step(2);
    `CHK(relay_error[1], 1'b1)
    `CHK(relay[1:0], 2'h0)
    summarize();
  end
endmodule
